// ---- verilog/cmo_regs.vh ----
// Purpose: register offsets, field positions and reset values of the message object control block
// Assumes: word-indexed registers on a plain strobe port
// Notes:   definitions only
`ifndef CMO_REGS_VH
`define CMO_REGS_VH

// register offsets
`define CMO_OFF_CTRL_SET   4'h0
`define CMO_OFF_CTRL_CLR   4'h1
`define CMO_OFF_CTRL       4'h2
`define CMO_OFF_FUNC       4'h3
`define CMO_OFF_ID         4'h4
`define CMO_OFF_DLC        4'h5
`define CMO_OFF_DATA_LO    4'h6
`define CMO_OFF_DATA_HI    4'h7
`define CMO_OFF_STATUS     4'h8

// control register bit positions
`define CMO_B_RX_UPDATING  0
`define CMO_B_NEW_DATA     1
`define CMO_B_MSG_LOST     2
`define CMO_B_OBJ_VALID    3
`define CMO_B_RX_TX_SEL    4
`define CMO_B_RX_ENABLE    5
`define CMO_B_TX_REQUEST   6
`define CMO_B_TX_ENABLE_A  7
`define CMO_B_TX_ENABLE_B  8
`define CMO_B_DIR          9
`define CMO_CTRL_W         10

// function register fields
`define CMO_MODE_LSB       0
`define CMO_MODE_MSB       3
`define CMO_B_SDT          4
`define CMO_B_STT          5
`define CMO_MODE_STANDARD  4'h0

// reset value of the control bits: transmit enables set
`define CMO_CTRL_RST       10'h180
`define CMO_FUNC_RST       6'h00

`endif

// ---- verilog/cmo_data_mem.v ----
// Purpose: two-word data field store with registered read port
// Assumes: single clock, one write port
// Notes:   holds the eight data bytes as two 32-bit words
`timescale 1ns/1ns
module cmo_data_mem #(
  parameter DW = 32,
  parameter AW = 1
) (
  // clock
  input  wire          sys_clk,
  // write port
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [DW-1:0] wr_data,
  // read port
  input  wire [AW-1:0] rd_addr,
  output reg  [DW-1:0] rd_data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // no reset: contents are undefined until software or a reception writes them
  always @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // cmo_data_mem

// ---- verilog/cmo_flag_reg.v ----
// Purpose: one control bit with software set/clear and hardware set/clear
// Assumes: pulses are one cycle wide
// Notes:   hardware set beats everything, software set beats hardware clear
`timescale 1ns/1ns
module cmo_flag_reg #(
  parameter RST = 1'b0
) (
  // clock and reset
  input  wire sys_clk,
  input  wire rst_n,
  // update requests
  input  wire sw_set,
  input  wire sw_clr,
  input  wire hw_set,
  input  wire hw_clr,
  // state
  output reg  flag_q
);
  reg flag_d;

  // fixed priority so no update is silently lost
  always @* begin
    flag_d = flag_q;
    if (hw_clr) flag_d = 1'b0;
    if (sw_clr) flag_d = 1'b0;
    if (sw_set) flag_d = 1'b1;
    if (hw_set) flag_d = 1'b1;
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= RST;
    end else begin
      flag_q <= flag_d;
    end
  end
endmodule // cmo_flag_reg

// ---- verilog/cmo_obj_ctrl.v ----
// Purpose: control logic of one CAN message object: transmit gating, copy to node buffer, flag handling
// Assumes: node engine gives one-cycle pulses; software uses the set/clear control registers
// Notes:   standard mode only; FIFO and gateway modes are outside this block
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ns
`include "cmo_regs.vh"

// Functional notes
// - transmit only when valid, request and both enables are all one
// - copy id, extended flag, direction as remote, length and data to node buffer
// - after selection remote and data frames follow the same path
// - clear request after success unless new data was set after copy
// - single transmit trial clears request when content is copied
// - matching received remote frame sets transmit request
// - remote requests accepted while enable a is low; sending waits
// - enable b is a second independent enable outside FIFOs
// - set selected bit when filtering picks object for transmission
// - copy proceeds to send only if selected bit is one
// - postprocessing after success only if selected bit still one
// - clear new data once content is in transmit buffer
// - updating, new data and lost flags same for data and remote
// - mode 0000 is standard; single transfer and single trial independent
// - further frame overwrites old content and raises lost flag
// - single transfer clears valid after storing received data frame only
// - single transfer clears valid after sending data frame only
// - clearing valid abandons ongoing hardware writes at once; a copy in LOAD and the high-word store still finish
// - storing sets new data; already set also sets lost flag
module cmo_obj_ctrl (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  // register port
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // transmit side of the node
  input  wire        tx_filter_win,
  input  wire        tx_buf_ready,
  output reg         tx_buf_load,
  output reg  [28:0] tx_buf_id,
  output reg         tx_buf_ide,
  output reg         tx_buf_rtr,
  output reg  [3:0]  tx_buf_dlc,
  output reg  [63:0] tx_buf_data,
  input  wire        tx_done_ok,
  // receive side of the node
  input  wire        rx_filter_win,
  input  wire        rx_frame_ok,
  input  wire        rx_frame_rtr,
  input  wire [3:0]  rx_frame_dlc,
  input  wire [63:0] rx_frame_data,
  // status towards the node
  output reg         tx_pending,
  output reg         tx_event,
  output reg         rx_event
);
  // copy sequence states
  localparam ST_IDLE = 2'd0;
  localparam ST_RDLO = 2'd1;
  localparam ST_RDHI = 2'd2;
  localparam ST_LOAD = 2'd3;
  // the copy takes three cycles from start to load: one per data word read,
  // then one to register the frame towards the node; the node sees a stable
  // buffer for as long as tx_pending stands

  // reset word of the control bits, sliced per flag below
  localparam [`CMO_CTRL_W-1:0] CTRL_RST_V = `CMO_CTRL_RST;

  // control bits
  wire [`CMO_CTRL_W-1:0] ctrl;
  reg  [`CMO_CTRL_W-1:0] hw_set;
  reg  [`CMO_CTRL_W-1:0] hw_clr;
  wire                   wr_set  = reg_wr && (reg_addr == `CMO_OFF_CTRL_SET);
  wire                   wr_clr  = reg_wr && (reg_addr == `CMO_OFF_CTRL_CLR);

  // object fields
  reg  [5:0]  func_q;
  reg  [28:0] id_q;
  reg         ide_q;
  reg  [3:0]  dlc_q;
  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [31:0] lo_q;
  reg         rx_busy_q;
  reg         rd_pend_q;
  reg  [3:0]  rd_addr_q;

  // data memory ports
  reg         mem_we;
  reg         mem_wa;
  reg  [31:0] mem_wd;
  reg         mem_ra;
  wire [31:0] mem_rd;

  wire valid   = ctrl[`CMO_B_OBJ_VALID];
  wire sel     = ctrl[`CMO_B_RX_TX_SEL];
  wire standard = (func_q[`CMO_MODE_MSB:`CMO_MODE_LSB] == `CMO_MODE_STANDARD);
  wire single_data_transfer     = func_q[`CMO_B_SDT] && standard;
  wire single_tx_trial     = func_q[`CMO_B_STT] && standard;
  // gating of transmission by the four bits
  wire tx_ok   = valid && ctrl[`CMO_B_TX_REQUEST] &&
                 ctrl[`CMO_B_TX_ENABLE_A] && ctrl[`CMO_B_TX_ENABLE_B];
  wire is_rtr  = ctrl[`CMO_B_DIR];

  // abandon is taken straight from the write strobe, not from the flag, so a
  // copy in RDLO or RDHI, or a storage in its first cycle, stops in the very cycle
  // of the write; a copy in LOAD and the high-word store still finish; nothing new starts once the object is invalid
  // software clearing valid abandons copies and storage in flight
  wire abandon = wr_clr && reg_wdata[`CMO_B_OBJ_VALID];

  genvar gi;
  generate
    for (gi = 0; gi < `CMO_CTRL_W; gi = gi + 1) begin : g_bit
      cmo_flag_reg #(
        .RST (CTRL_RST_V[gi])
      ) u_bit (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .sw_set  (wr_set && reg_wdata[gi]),
        .sw_clr  (wr_clr && reg_wdata[gi]),
        .hw_set  (hw_set[gi]),
        .hw_clr  (hw_clr[gi]),
        .flag_q  (ctrl[gi])
      );
    end
  endgenerate

  cmo_data_mem #(
    .DW (32),
    .AW (1)
  ) u_mem (
    .sys_clk (sys_clk),
    .wr_en   (mem_we),
    .wr_addr (mem_wa),
    .wr_data (mem_wd),
    .rd_addr (mem_ra),
    .rd_data (mem_rd)
  );

  // the start condition also needs a free node buffer and no frame in flight,
  // so a second copy can never overwrite a frame the node has not sent yet
  // limitation: a copy started just before a software write to the data words
  // may send the old words; software is expected to drop enable a first
  // while it rewrites them
  // copy sequence: read both data words, then hand the frame to the node
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (tx_ok && sel && tx_buf_ready && !tx_pending && !abandon) begin
          state_d = ST_RDLO;
        end
      end
      ST_RDLO: state_d = abandon ? ST_IDLE : ST_RDHI;
      ST_RDHI: state_d = abandon ? ST_IDLE : ST_LOAD;
      ST_LOAD: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // hardware flag updates
  // each request is a one-cycle pulse into the flag cells; the cells resolve a
  // clash with a software write, and a hardware set always wins so that an
  // event that lands beside a clear from software is never lost
  // a frame that ends after hardware dropped the valid bit is not stored, and
  // the updating flag is still released; a software drop in the frame's first cycle leaves the flag set
  always @* begin
    hw_set = {`CMO_CTRL_W{1'b0}};
    hw_clr = {`CMO_CTRL_W{1'b0}};
    // selection by transmit or receive filtering
    if ((tx_filter_win || rx_filter_win) && valid) begin
      hw_set[`CMO_B_RX_TX_SEL] = 1'b1;
    end
    // copy: new data cleared, single trial drops the request
    if (state_q == ST_LOAD && sel && valid && tx_ok) begin
      hw_clr[`CMO_B_NEW_DATA] = 1'b1;
      if (single_tx_trial) begin
        hw_clr[`CMO_B_TX_REQUEST] = 1'b1;
      end
    end
    // postprocessing only while still selected; remote and data share it
    if (tx_done_ok && tx_pending && sel && valid) begin
      if (!ctrl[`CMO_B_NEW_DATA]) begin
        hw_clr[`CMO_B_TX_REQUEST] = 1'b1;
      end
      hw_clr[`CMO_B_RX_TX_SEL] = 1'b1;
      if (single_data_transfer && !is_rtr) begin
        hw_clr[`CMO_B_OBJ_VALID] = 1'b1;
      end
    end
    // reception start marks updating
    if (rx_frame_ok && sel && valid) begin
      hw_set[`CMO_B_RX_UPDATING] = 1'b1;
    end
    // reception finish: flags set alike for data and remote frames
    if (rx_busy_q && valid) begin
      hw_clr[`CMO_B_RX_UPDATING] = 1'b1;
      hw_set[`CMO_B_NEW_DATA] = 1'b1;
      if (ctrl[`CMO_B_NEW_DATA]) begin
        hw_set[`CMO_B_MSG_LOST] = 1'b1;
      end
      hw_clr[`CMO_B_RX_TX_SEL] = 1'b1;
      if (rx_frame_rtr) begin
        hw_set[`CMO_B_TX_REQUEST] = 1'b1;
      end else if (single_data_transfer) begin
        hw_clr[`CMO_B_OBJ_VALID] = 1'b1;
      end
    end
    if (rx_busy_q && !valid) begin
      hw_clr[`CMO_B_RX_UPDATING] = 1'b1;
    end
  end

  // data memory: software writes, reception overwrites, copy reads
  always @* begin
    mem_we = 1'b0;
    mem_wa = 1'b0;
    mem_wd = reg_wdata;
    // address the low word while in RDLO so it stands during RDHI, where it is
    // captured; the high word is addressed in RDHI and stands during LOAD
    mem_ra = (state_q == ST_RDHI);
    if (reg_wr && (reg_addr == `CMO_OFF_DATA_LO || reg_addr == `CMO_OFF_DATA_HI)) begin
      mem_we = 1'b1;
      mem_wa = (reg_addr == `CMO_OFF_DATA_HI);
    end else if (rx_frame_ok && sel && valid && !abandon && !rx_frame_rtr) begin
      mem_we = 1'b1;
      mem_wd = rx_frame_data[31:0];
    end else if (rx_busy_q && valid && !rx_frame_rtr) begin
      mem_we = 1'b1;
      mem_wa = 1'b1;
      mem_wd = rx_frame_data[63:32];
    end
    if (reg_rd && (reg_addr == `CMO_OFF_DATA_LO || reg_addr == `CMO_OFF_DATA_HI) && state_q == ST_IDLE) begin
      mem_ra = (reg_addr == `CMO_OFF_DATA_HI);
    end
  end

  // software fields are written through their own offsets, dlc_q also on reception; the control
  // bits live in the flag cells above and are reached via the set and clear
  // offsets, which removes any read-modify-write race with the hardware
  // sequencer, node buffer and software fields
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= ST_IDLE;
      func_q      <= `CMO_FUNC_RST;
      id_q        <= 29'h0000000;
      ide_q       <= 1'b0;
      dlc_q       <= 4'h0;
      lo_q        <= 32'h00000000;
      rx_busy_q   <= 1'b0;
      tx_buf_load <= 1'b0;
      tx_buf_id   <= 29'h0000000;
      tx_buf_ide  <= 1'b0;
      tx_buf_rtr  <= 1'b0;
      tx_buf_dlc  <= 4'h0;
      tx_buf_data <= 64'h0000000000000000;
      tx_pending  <= 1'b0;
      tx_event    <= 1'b0;
      rx_event    <= 1'b0;
    end else begin
      state_q     <= state_d;
      tx_buf_load <= 1'b0;
      tx_event    <= 1'b0;
      rx_event    <= 1'b0;
      rx_busy_q   <= rx_frame_ok && sel && valid && !abandon;
      if (state_q == ST_RDHI) begin
        lo_q <= mem_rd;
      end
      // the buffer outputs are registered and hold between loads, so the node
      // may sample them at any time while tx_pending stands
      // load the node buffer; remote frames carry no data field
      if (state_q == ST_LOAD && sel && valid && tx_ok) begin
        tx_buf_load <= 1'b1;
        tx_buf_id   <= id_q;
        tx_buf_ide  <= ide_q;
        tx_buf_rtr  <= is_rtr;
        tx_buf_dlc  <= dlc_q;
        tx_buf_data <= is_rtr ? 64'h0000000000000000 : {mem_rd, lo_q};
        tx_pending  <= 1'b1;
      end
      if (tx_done_ok && tx_pending) begin
        tx_pending <= 1'b0;
        tx_event   <= sel && valid;
      end else if (abandon) begin
        tx_pending <= 1'b0;
      end
      // length code is stored for remote frames too; only the data field is skipped
      if (rx_busy_q && valid) begin
        rx_event <= 1'b1;
        dlc_q    <= rx_frame_dlc;
      end
      // software fields
      if (reg_wr && reg_addr == `CMO_OFF_FUNC) begin
        func_q <= reg_wdata[5:0];
      end
      if (reg_wr && reg_addr == `CMO_OFF_ID) begin
        id_q  <= reg_wdata[28:0];
        ide_q <= reg_wdata[29];
      end
      if (reg_wr && reg_addr == `CMO_OFF_DLC) begin
        dlc_q <= reg_wdata[3:0];
      end
    end
  end

  // the data words are write-only from the register port: reading them back
  // would need a second read port on the store, or a stall of the copy
  // sequence, and software has no need for the data it wrote itself
  // read data stand the cycle after the strobe
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_pend_q <= 1'b0;
      rd_addr_q <= 4'h0;
      reg_rdata <= 32'h00000000;
    end else begin
      rd_pend_q <= reg_rd;
      rd_addr_q <= reg_addr;
      reg_rdata <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          `CMO_OFF_CTRL_SET,
          `CMO_OFF_CTRL_CLR,
          `CMO_OFF_CTRL:    reg_rdata <= {22'h000000, ctrl};
          `CMO_OFF_FUNC:    reg_rdata <= {26'h0000000, func_q};
          `CMO_OFF_ID:      reg_rdata <= {2'h0, ide_q, id_q};
          `CMO_OFF_DLC:     reg_rdata <= {28'h0000000, dlc_q};
          `CMO_OFF_STATUS:  reg_rdata <= {29'h00000000, tx_pending, state_q};
          default:          reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // cmo_obj_ctrl

// ---- test/cmo_node_model.sv ----
// Purpose: behavioural node engine facing one message object
// Assumes: one frame on the bus at a time, success dly+1 cycles after load
// Notes:   receive lines show inverted values outside their hold window
`timescale 1ns/1ns
module cmo_node_model (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  // bench control
  input  wire [3:0]  dly,
  input  wire        rx_go,
  input  wire        rx_rtr,
  // transmit side
  input  wire        tx_buf_load,
  output wire        tx_buf_ready,
  output reg         tx_done_ok,
  // receive side
  output reg         rx_filter_win,
  output reg         rx_frame_ok,
  output wire        rx_frame_rtr,
  output wire [3:0]  rx_frame_dlc,
  output wire [63:0] rx_frame_data
);
  reg  [3:0] cnt_q;
  reg        hold_q;
  wire       win = rx_frame_ok | hold_q;
  // stale lines inverted so the object cannot pass on leftovers by luck
  assign tx_buf_ready  = (cnt_q == 4'h0);
  assign rx_frame_rtr  = win ? rx_rtr : ~rx_rtr;
  assign rx_frame_dlc  = win ? 4'h5 : 4'ha;
  assign rx_frame_data = win ? 64'h0123456789abcdef : ~64'h0123456789abcdef;
  // bus time countdown and receive sequence: filter, then frame held two cycles
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q         <= 4'h0;
      tx_done_ok    <= 1'b0;
      rx_filter_win <= 1'b0;
      rx_frame_ok   <= 1'b0;
      hold_q        <= 1'b0;
    end else begin
      if (tx_buf_load)
        cnt_q <= dly;
      else if (cnt_q != 4'h0)
        cnt_q <= cnt_q - 4'h1;
      tx_done_ok    <= (cnt_q == 4'h1);
      rx_filter_win <= rx_go;
      rx_frame_ok   <= rx_filter_win;
      hold_q        <= rx_frame_ok;
    end
  end
endmodule // cmo_node_model

// ---- test/cmo_obj_ctrl_props.sv ----
// Purpose: port-level checks of the message object control block
// Assumes: single clock, async active-low reset
// Notes:   load comes four edges after the start condition
`timescale 1ns/1ns
module cmo_obj_ctrl_props (
  // clock and reset
  input wire        sys_clk,
  input wire        rst_n,
  // node side
  input wire        tx_buf_ready,
  input wire        tx_buf_load,
  input wire [28:0] tx_buf_id,
  input wire        tx_done_ok,
  input wire        rx_frame_ok,
  input wire        tx_pending,
  input wire        tx_event,
  input wire        rx_event
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_LOAD_PULSE: assert property (tx_buf_load |=> !tx_buf_load)
    else $error("load longer than one cycle");
  AST_LOAD_READY: assert property (tx_buf_load |-> $past(tx_buf_ready, 4))
    else $error("load without free buffer");
  AST_LOAD_PEND: assert property (tx_buf_load |-> tx_pending && !$past(tx_pending))
    else $error("load while a frame pending");
  AST_PEND_RISE: assert property ($rose(tx_pending) |-> tx_buf_load)
    else $error("pending without load");
  AST_DONE_END: assert property (tx_pending && tx_done_ok |=> !tx_pending)
    else $error("pending kept after success");
  AST_TX_EVENT: assert property (tx_event |-> $past(tx_done_ok) && $past(tx_pending))
    else $error("tx event without success");
  AST_RX_EVENT: assert property (rx_event |-> $past(rx_frame_ok, 2))
    else $error("rx event without frame");
  AST_FRAME_HOLD: assert property (!tx_buf_load |-> $stable(tx_buf_id))
    else $error("frame id moved between loads");
  cover property (tx_buf_load);
  cover property (tx_event);
  cover property (rx_event);
endmodule // cmo_obj_ctrl_props
bind cmo_obj_ctrl cmo_obj_ctrl_props u_props (.sys_clk(sys_clk), .rst_n(rst_n), .tx_buf_ready(tx_buf_ready),
  .tx_buf_load(tx_buf_load), .tx_buf_id(tx_buf_id), .tx_done_ok(tx_done_ok), .rx_frame_ok(rx_frame_ok),
  .tx_pending(tx_pending), .tx_event(tx_event), .rx_event(rx_event));

// ---- test/cmo_obj_ctrl_tb.sv ----
// Purpose: self-checking bench of the message object control block
// Assumes: node model on the far side, bench acts as software
// Notes:   expected control words follow the bit map of cmo_regs.vh
`timescale 1ns/1ns
`include "cmo_regs.vh"
module cmo_obj_ctrl_tb;
  reg         sys_clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [3:0]  reg_addr = 4'h0;
  reg  [31:0] reg_wdata = 32'h0;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg         tx_filter_win = 1'b0;
  reg         rx_go = 1'b0;
  reg         rx_rtr = 1'b0;
  reg  [3:0]  dly = 4'hf;
  reg  [31:0] blk [0:2];
  wire [31:0] reg_rdata;
  wire [28:0] tx_buf_id;
  wire [3:0]  tx_buf_dlc, rx_frame_dlc;
  wire [63:0] tx_buf_data, rx_frame_data;
  wire        tx_buf_ready, tx_buf_load, tx_buf_ide, tx_buf_rtr, tx_done_ok, rx_filter_win;
  wire        rx_frame_ok, rx_frame_rtr, tx_pending, tx_event, rx_event;
  integer     miscompares = 0;
  integer     tests_run = 0;
  integer     nload = 0;
  integer     i;
  cmo_obj_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_filter_win(tx_filter_win),
    .tx_buf_ready(tx_buf_ready), .tx_buf_load(tx_buf_load), .tx_buf_id(tx_buf_id), .tx_buf_ide(tx_buf_ide),
    .tx_buf_rtr(tx_buf_rtr), .tx_buf_dlc(tx_buf_dlc), .tx_buf_data(tx_buf_data), .tx_done_ok(tx_done_ok),
    .rx_filter_win(rx_filter_win), .rx_frame_ok(rx_frame_ok), .rx_frame_rtr(rx_frame_rtr),
    .rx_frame_dlc(rx_frame_dlc), .rx_frame_data(rx_frame_data), .tx_pending(tx_pending),
    .tx_event(tx_event), .rx_event(rx_event));
  cmo_node_model u_node (.sys_clk(sys_clk), .rst_n(rst_n), .dly(dly), .rx_go(rx_go), .rx_rtr(rx_rtr),
    .tx_buf_load(tx_buf_load), .tx_buf_ready(tx_buf_ready), .tx_done_ok(tx_done_ok),
    .rx_filter_win(rx_filter_win), .rx_frame_ok(rx_frame_ok), .rx_frame_rtr(rx_frame_rtr),
    .rx_frame_dlc(rx_frame_dlc), .rx_frame_data(rx_frame_data));
  // clock and watchdog; the run needs well under 3000 cycles
  initial forever #2 sys_clk = ~sys_clk;
  initial begin
    #40000;
    miscompares = miscompares + 1;
    results;
  end
  // count loads so that a blocked object is seen to stay quiet
  always @(posedge sys_clk) if (tx_buf_load === 1'b1) nload <= nload + 1;
  task results;
    begin
      if (miscompares == 0 && tests_run > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input [63:0] got, input [63:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, input [31:0] e);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
    end
  endtask
  // wait for load (0), tx event (1) or rx event (2), bounded
  task wt(input [1:0] k);
    integer n;
    begin
      n = 0;
      #1;
      while (n < 40 && (k == 2'd0 ? tx_buf_load : k == 2'd1 ? tx_event : rx_event) !== 1'b1) begin
        @(posedge sys_clk);
        #1 n = n + 1;
      end
      chk(n < 40, 64'h1);
    end
  endtask
  task sel;
    begin
      @(posedge sys_clk);
      tx_filter_win <= 1'b1;
      @(posedge sys_clk);
      tx_filter_win <= 1'b0;
    end
  endtask
  task rxf(input r);
    begin
      @(posedge sys_clk);
      rx_go <= 1'b1;
      rx_rtr <= r;
      @(posedge sys_clk);
      rx_go <= 1'b0;
      wt(2'd2);
    end
  endtask
  initial begin
    blk[0] = 32'h8;
    blk[1] = 32'h80;
    blk[2] = 32'h100;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(`CMO_OFF_CTRL, 32'h180);
    rd(`CMO_OFF_FUNC, 32'h0);
    rd(4'hf, 32'h0);
    // extended data frame, then new data written during the transfer
    wr(`CMO_OFF_ID, 32'h2000_0123);
    wr(`CMO_OFF_DLC, 32'h8);
    wr(`CMO_OFF_DATA_LO, 32'h89ab_cdef);
    wr(`CMO_OFF_DATA_HI, 32'h0123_4567);
    wr(`CMO_OFF_CTRL_SET, 32'h4a);
    sel;
    wt(2'd0);
    chk({tx_buf_ide, tx_buf_rtr, tx_buf_id, tx_buf_dlc}, {2'b10, 29'h123, 4'h8});
    chk(tx_buf_data, 64'h0123456789abcdef);
    rd(`CMO_OFF_CTRL, 32'h1d8);
    wt(2'd1);
    rd(`CMO_OFF_CTRL, 32'h188);
    wr(`CMO_OFF_CTRL_SET, 32'h40);
    sel;
    wt(2'd0);
    wr(`CMO_OFF_CTRL_SET, 32'h2);
    wt(2'd1);
    rd(`CMO_OFF_CTRL, 32'h1ca);
    wr(`CMO_OFF_CTRL_CLR, 32'h42);
    // valid and both enables each block alone, with a prompt node
    dly <= 4'h1;
    for (i = 0; i < 3; i = i + 1) begin
      wr(`CMO_OFF_CTRL_CLR, blk[i]);
      wr(`CMO_OFF_CTRL_SET, 32'h40);
      sel;
      repeat (12) @(posedge sys_clk);
      chk(nload, 2 + i);
      wr(`CMO_OFF_CTRL_SET, blk[i]);
      sel;
      wt(2'd1);
      rd(`CMO_OFF_CTRL, 32'h188);
    end
    // remote request while enable a is low, with a slow node
    dly <= 4'hf;
    wr(`CMO_OFF_CTRL_CLR, 32'h80);
    rxf(1'b1);
    rd(`CMO_OFF_CTRL, 32'h14a);
    repeat (8) @(posedge sys_clk);
    chk(nload, 5);
    wr(`CMO_OFF_CTRL_SET, 32'h80);
    sel;
    wt(2'd0);
    chk(tx_buf_dlc, 4'h5);
    wt(2'd1);
    // overrun, then single data transfer both ways
    wr(`CMO_OFF_DATA_LO, 32'h0);
    rxf(1'b0);
    rxf(1'b0);
    rd(`CMO_OFF_CTRL, 32'h18e);
    wr(`CMO_OFF_CTRL_CLR, 32'h6);
    wr(`CMO_OFF_FUNC, 32'h10);
    rxf(1'b0);
    rd(`CMO_OFF_CTRL, 32'h182);
    wr(`CMO_OFF_CTRL_CLR, 32'h2);
    wr(`CMO_OFF_CTRL_SET, 32'h8);
    rxf(1'b1);
    rd(`CMO_OFF_CTRL, 32'h1ca);
    sel;
    wt(2'd1);
    chk(tx_buf_data, 64'h0123456789abcdef);
    rd(`CMO_OFF_CTRL, 32'h180);
    // single trial, then a remote frame sent under single transfer
    wr(`CMO_OFF_FUNC, 32'h20);
    wr(`CMO_OFF_CTRL_SET, 32'h48);
    sel;
    wt(2'd0);
    rd(`CMO_OFF_CTRL, 32'h198);
    wt(2'd1);
    wr(`CMO_OFF_FUNC, 32'h10);
    wr(`CMO_OFF_CTRL_SET, 32'h248);
    sel;
    wt(2'd0);
    chk(tx_buf_rtr, 64'h1);
    chk(tx_buf_data, 64'h0);
    wt(2'd1);
    rd(`CMO_OFF_CTRL, 32'h388);
    results;
  end
endmodule // cmo_obj_ctrl_tb
